// ==== logic/dmcp_consts.vh ====
`ifndef DMCP_CONSTS_VH
`define DMCP_CONSTS_VH

// ------------------------------------------------------------
// control word layout
// ------------------------------------------------------------
`define DMCP_WORD_BITS        5'd16
`define DMCP_CNT_OVER         5'd17
`define DMCP_IDX_MSB          14
`define DMCP_IDX_LSB          8
`define DMCP_DATA_MSB         7

// ------------------------------------------------------------
// register indexes
// ------------------------------------------------------------
`define DMCP_IDX_LEFT_ATTEN   7'h10
`define DMCP_IDX_RIGHT_ATTEN  7'h11
`define DMCP_IDX_MUTE_RST_OVS 7'h12
`define DMCP_IDX_DEEMPH_DAC   7'h13
`define DMCP_IDX_FMT_FILTER   7'h14
`define DMCP_IDX_ATTEN_MODE   7'h15
`define DMCP_IDX_PHASE_FLAG   7'h16

// ------------------------------------------------------------
// reset values and writable-bit masks
// ------------------------------------------------------------
`define DMCP_RST_ATTEN        8'hff
`define DMCP_RST_ZERO         8'h00
`define DMCP_MASK_MUTE_RST    8'hc3
`define DMCP_MASK_DEEMPH_DAC  8'h73
`define DMCP_MASK_FMT_FILTER  8'h27
`define DMCP_MASK_ATTEN_MODE  8'h01
`define DMCP_MASK_PHASE_FLAG  8'h07

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DMCP_BIT_SOFT_RESET   7
`define DMCP_BIT_OVERSAMPLE   6
`define DMCP_BIT_RIGHT_MUTE   1
`define DMCP_BIT_LEFT_MUTE    0
`define DMCP_BIT_DEEMPH_EN    4
`define DMCP_BIT_RIGHT_DAC    1
`define DMCP_BIT_LEFT_DAC     0
`define DMCP_BIT_ROLLOFF      5
`define DMCP_BIT_ATTEN_MODE   0
`define DMCP_BIT_COMBINE      2
`define DMCP_BIT_POLARITY     1
`define DMCP_BIT_PHASE        0

// ------------------------------------------------------------
// codes and counts
// ------------------------------------------------------------
`define DMCP_DEEMPH_441       2'h0
`define DMCP_DEEMPH_48        2'h1
`define DMCP_DEEMPH_32        2'h2
`define DMCP_FMT_I2S          3'h4
`define DMCP_FMT_RJ16         3'h0
`define DMCP_MUTE_CODE_HALF   8'h80
`define DMCP_MUTE_CODE_FULL   8'h9a
`define DMCP_ZERO_PERIODS     1024
`define DMCP_SOFT_RESET_BIT_CLOCKS      1024

`endif

// ==== logic/dmcp_zero_detect.v ====
`timescale 1ns/1ns
`include "dmcp_consts.vh"

module dmcp_zero_detect #(
    parameter PERIODS = `DMCP_ZERO_PERIODS,
    parameter CNT_W   = 11
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire             i_ce,
    // sample stream
    input  wire             i_clear,
    input  wire             i_period,
    input  wire             i_zero,
    // result
    output reg              o_detect
);

    localparam [CNT_W-1:0] LIMIT = PERIODS[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------
    // zero-run counter, saturates at the limit
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r    <= {CNT_W{1'b0}};
            o_detect <= 1'b0;
        end else if (i_ce) begin
            if (i_clear) begin
                cnt_r <= {CNT_W{1'b0}};
            end else if (i_period) begin
                if (!i_zero) begin
                    cnt_r <= {CNT_W{1'b0}};
                end else if (cnt_r != LIMIT) begin
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            o_detect <= (cnt_r == LIMIT) && !i_clear;
        end
    end

endmodule

// ==== logic/dmcp_top.v ====
// Operation
// - channel zero after 1024 zero word periods
// - zero flag active while channel zero holds
// - polarity bit inverts left/right flags active-low (serial variant only)
// - combine bit merges both channels into one
// - pin variant common flag needs both zero
// - format pin selects I2S or RJ16
// - two de-emphasis pins select rate or off
// - mute pin high mutes, low releases
// - write-only port: select, clock, data
// - word: bit15, seven-bit index, eight data
// - select rise after sixteen clocks stores data
// - indexes 10h-16h; attenuation resets to 0dB
// - 12h: reset, oversampling, right/left mute
// - 13h: de-emphasis rate, enable, DAC disables
// - 14h: rolloff bit and three-bit format
// - 15h attenuation mode; 16h flag/phase bits
// - soft reset: 1024 clocks, registers default
// - code 255 is 0dB; low codes mute
`timescale 1ns/1ns
`include "dmcp_consts.vh"

module dmcp_top #(
    parameter PIN_CONTROL = 0,
    parameter SAMPLE_W    = 24,
    parameter ZERO_CNT_W  = 11,
    parameter SOFT_RESET_BIT_CNT_W  = 11
) (
    // clock and reset
    input  wire                i_clk,
    input  wire                i_rst_n,
    input  wire                i_ce,
    // serial control port pins
    input  wire                i_port_select_n,
    input  wire                i_port_shift_clock,
    input  wire                i_port_serial_in,
    // hardware-control pins
    input  wire                i_format_pin,
    input  wire                i_deemph_sel_hi_pin,
    input  wire                i_deemph_sel_lo_pin,
    input  wire                i_mute_pin,
    // audio samples, same clock domain, word clock from pin
    input  wire                i_word_clock,
    input  wire [SAMPLE_W-1:0] i_left_sample,
    input  wire [SAMPLE_W-1:0] i_right_sample,
    // zero flags
    output reg                 o_left_zero_flag,
    output reg                 o_right_zero_flag,
    output reg                 o_common_zero_flag,
    // mode outputs
    output reg  [7:0]          o_left_atten_level,
    output reg  [7:0]          o_right_atten_level,
    output reg                 o_left_atten_mute,
    output reg                 o_right_atten_mute,
    output reg                 o_left_soft_mute,
    output reg                 o_right_soft_mute,
    output reg                 o_oversample_boost,
    output reg                 o_left_dac_disable,
    output reg                 o_right_dac_disable,
    output reg                 o_deemph_enable,
    output reg  [1:0]          o_deemph_rate_select,
    output reg                 o_rolloff_select,
    output reg  [2:0]          o_format_field,
    output reg                 o_atten_mode_select,
    output reg                 o_output_phase_invert,
    output reg                 o_soft_reset_active
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // mute threshold depends on step size
    function atten_is_mute;
        input [7:0] code;
        input       mode;
        begin
            if (mode) begin
                atten_is_mute = (code <= `DMCP_MUTE_CODE_FULL);
            end else begin
                atten_is_mute = (code <= `DMCP_MUTE_CODE_HALF);
            end
        end
    endfunction

    function rising;
        input prev;
        input now;
        begin
            rising = now & ~prev;
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // first stage feeds only the second stage
    reg [7:0] meta_r;
    reg [7:0] sync_r;
    reg       sck_d_r;
    reg       sel_d_r;
    reg       wck_d_r;

    wire [7:0] pins_in = {i_port_select_n, i_port_shift_clock, i_port_serial_in,
                          i_format_pin, i_deemph_sel_hi_pin, i_deemph_sel_lo_pin,
                          i_mute_pin, i_word_clock};

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r  <= 8'h80;
            sync_r  <= 8'h80;
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
            wck_d_r <= 1'b0;
        end else if (i_ce) begin
            meta_r  <= pins_in;
            sync_r  <= meta_r;
            sck_d_r <= sync_r[6];
            sel_d_r <= sync_r[7];
            wck_d_r <= sync_r[0];
        end
    end

    wire sel_n_s  = sync_r[7];
    wire sck_s    = sync_r[6];
    wire sdi_s    = sync_r[5];
    wire fmt_s    = sync_r[4];
    wire dm_hi_s  = sync_r[3];
    wire dm_lo_s  = sync_r[2];
    wire mute_s   = sync_r[1];
    wire wck_s    = sync_r[0];

    wire sck_rise = rising(sck_d_r, sck_s);
    wire sel_rise = rising(sel_d_r, sel_n_s);
    wire sel_fall = sel_d_r & ~sel_n_s;
    wire wck_rise = rising(wck_d_r, wck_s);

    // ------------------------------------------------------------
    // serial word receiver
    // ------------------------------------------------------------
    reg [15:0] shift_r;
    reg [4:0]  bit_cnt_r;

    // the port only takes writes; nothing is ever shifted out
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_r   <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end else if (i_ce) begin
            if (sel_fall) begin
                bit_cnt_r <= 5'h00;
            end else if (!sel_n_s && sck_rise) begin
                shift_r <= {shift_r[14:0], sdi_s};
                // extra clocks park the count past sixteen so the word is dropped
                if (bit_cnt_r != `DMCP_CNT_OVER) begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
            end
        end
    end

    // bit 15 is left unchecked; the host keeps it zero
    wire [6:0] rx_index = shift_r[`DMCP_IDX_MSB:`DMCP_IDX_LSB];
    wire [7:0] rx_data  = shift_r[`DMCP_DATA_MSB:0];
    wire       word_ok  = sel_rise && (bit_cnt_r == `DMCP_WORD_BITS);

    // ------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------
    reg [7:0]            left_attenuation_r;
    reg [7:0]            right_attenuation_r;
    reg [7:0]            mute_reset_oversampling_r;
    reg [7:0]            deemphasis_dac_enable_r;
    reg [7:0]            format_and_filter_r;
    reg [7:0]            attenuation_mode_r;
    reg [7:0]            phase_and_flag_options_r;
    reg [SOFT_RESET_BIT_CNT_W-1:0] soft_reset_bit_cnt_r;
    reg                  soft_reset_bit_busy_r;

    localparam integer          SOFT_RESET_BIT_LAST_INT = `DMCP_SOFT_RESET_BIT_CLOCKS - 1;
    localparam [SOFT_RESET_BIT_CNT_W-1:0] SOFT_RESET_BIT_LAST     = SOFT_RESET_BIT_LAST_INT[SOFT_RESET_BIT_CNT_W-1:0];

    wire soft_reset_bit_req = word_ok && !soft_reset_bit_busy_r && (rx_index == `DMCP_IDX_MUTE_RST_OVS) &&
                    rx_data[`DMCP_BIT_SOFT_RESET];

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_attenuation_r        <= `DMCP_RST_ATTEN;
            right_attenuation_r       <= `DMCP_RST_ATTEN;
            mute_reset_oversampling_r <= `DMCP_RST_ZERO;
            deemphasis_dac_enable_r   <= `DMCP_RST_ZERO;
            format_and_filter_r       <= `DMCP_RST_ZERO;
            attenuation_mode_r        <= `DMCP_RST_ZERO;
            phase_and_flag_options_r  <= `DMCP_RST_ZERO;
            soft_reset_bit_cnt_r                <= {SOFT_RESET_BIT_CNT_W{1'b0}};
            soft_reset_bit_busy_r               <= 1'b0;
        end else if (i_ce) begin
            if (soft_reset_bit_busy_r || soft_reset_bit_req) begin
                // soft reset holds defaults and refuses writes for its whole period
                left_attenuation_r        <= `DMCP_RST_ATTEN;
                right_attenuation_r       <= `DMCP_RST_ATTEN;
                mute_reset_oversampling_r <= `DMCP_RST_ZERO;
                deemphasis_dac_enable_r   <= `DMCP_RST_ZERO;
                format_and_filter_r       <= `DMCP_RST_ZERO;
                attenuation_mode_r        <= `DMCP_RST_ZERO;
                phase_and_flag_options_r  <= `DMCP_RST_ZERO;
                if (soft_reset_bit_req) begin
                    soft_reset_bit_busy_r <= 1'b1;
                    soft_reset_bit_cnt_r  <= {SOFT_RESET_BIT_CNT_W{1'b0}};
                end else if (soft_reset_bit_cnt_r == SOFT_RESET_BIT_LAST) begin
                    soft_reset_bit_busy_r <= 1'b0;
                end else begin
                    soft_reset_bit_cnt_r <= soft_reset_bit_cnt_r + {{(SOFT_RESET_BIT_CNT_W-1){1'b0}}, 1'b1};
                end
            end else if (word_ok) begin
                case (rx_index)
                    `DMCP_IDX_LEFT_ATTEN: begin
                        left_attenuation_r <= rx_data;
                    end
                    `DMCP_IDX_RIGHT_ATTEN: begin
                        right_attenuation_r <= rx_data;
                    end
                    `DMCP_IDX_MUTE_RST_OVS: begin
                        mute_reset_oversampling_r <= rx_data & `DMCP_MASK_MUTE_RST;
                    end
                    `DMCP_IDX_DEEMPH_DAC: begin
                        deemphasis_dac_enable_r <= rx_data & `DMCP_MASK_DEEMPH_DAC;
                    end
                    `DMCP_IDX_FMT_FILTER: begin
                        format_and_filter_r <= rx_data & `DMCP_MASK_FMT_FILTER;
                    end
                    `DMCP_IDX_ATTEN_MODE: begin
                        attenuation_mode_r <= rx_data & `DMCP_MASK_ATTEN_MODE;
                    end
                    `DMCP_IDX_PHASE_FLAG: begin
                        phase_and_flag_options_r <= rx_data & `DMCP_MASK_PHASE_FLAG;
                    end
                    default: begin
                        // out-of-range index: nothing changes
                        soft_reset_bit_busy_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // zero detection
    // ------------------------------------------------------------
    // samples come from same-clock logic and are looked at once per word period
    wire left_is_zero  = (i_left_sample == {SAMPLE_W{1'b0}});
    wire right_is_zero = (i_right_sample == {SAMPLE_W{1'b0}});
    wire left_det;
    wire right_det;

    dmcp_zero_detect #(
        .PERIODS (`DMCP_ZERO_PERIODS),
        .CNT_W   (ZERO_CNT_W)
    ) u_zero_left (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_clear  (soft_reset_bit_busy_r),
        .i_period (wck_rise),
        .i_zero   (left_is_zero),
        .o_detect (left_det)
    );

    dmcp_zero_detect #(
        .PERIODS (`DMCP_ZERO_PERIODS),
        .CNT_W   (ZERO_CNT_W)
    ) u_zero_right (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_clear  (soft_reset_bit_busy_r),
        .i_period (wck_rise),
        .i_zero   (right_is_zero),
        .o_detect (right_det)
    );

    // ------------------------------------------------------------
    // zero flag shaping
    // ------------------------------------------------------------
    wire both_det    = left_det & right_det;
    wire combine_sel = phase_and_flag_options_r[`DMCP_BIT_COMBINE];
    wire polarity    = phase_and_flag_options_r[`DMCP_BIT_POLARITY];
    reg  left_flag_nxt;
    reg  right_flag_nxt;

    always @* begin
        if (PIN_CONTROL != 0) begin
            left_flag_nxt  = both_det;
            right_flag_nxt = both_det;
        end else if (combine_sel) begin
            left_flag_nxt  = both_det ^ polarity;
            right_flag_nxt = both_det ^ polarity;
        end else begin
            left_flag_nxt  = left_det ^ polarity;
            right_flag_nxt = right_det ^ polarity;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_left_zero_flag   <= 1'b0;
            o_right_zero_flag  <= 1'b0;
            o_common_zero_flag <= 1'b0;
        end else if (i_ce) begin
            o_left_zero_flag   <= left_flag_nxt;
            o_right_zero_flag  <= right_flag_nxt;
            o_common_zero_flag <= both_det;
        end
    end

    // ------------------------------------------------------------
    // mode outputs, software or pin source
    // ------------------------------------------------------------
    reg [1:0] pin_rate;
    reg [2:0] fmt_nxt;

    always @* begin
        pin_rate = `DMCP_DEEMPH_441;
        case ({dm_hi_s, dm_lo_s})
            2'b01: begin
                pin_rate = `DMCP_DEEMPH_48;
            end
            2'b10: begin
                pin_rate = `DMCP_DEEMPH_441;
            end
            2'b11: begin
                pin_rate = `DMCP_DEEMPH_32;
            end
            default: begin
                pin_rate = `DMCP_DEEMPH_441;
            end
        endcase
        fmt_nxt = fmt_s ? `DMCP_FMT_RJ16 : `DMCP_FMT_I2S;
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_left_atten_level    <= `DMCP_RST_ATTEN;
            o_right_atten_level   <= `DMCP_RST_ATTEN;
            o_left_atten_mute     <= 1'b0;
            o_right_atten_mute    <= 1'b0;
            o_left_soft_mute      <= 1'b0;
            o_right_soft_mute     <= 1'b0;
            o_oversample_boost    <= 1'b0;
            o_left_dac_disable    <= 1'b0;
            o_right_dac_disable   <= 1'b0;
            o_deemph_enable       <= 1'b0;
            o_deemph_rate_select  <= `DMCP_DEEMPH_441;
            o_rolloff_select      <= 1'b0;
            o_format_field        <= 3'h0;
            o_atten_mode_select   <= 1'b0;
            o_output_phase_invert <= 1'b0;
            o_soft_reset_active   <= 1'b0;
        end else if (i_ce) begin
            o_left_atten_level    <= left_attenuation_r;
            o_right_atten_level   <= right_attenuation_r;
            o_left_atten_mute     <= atten_is_mute(left_attenuation_r,
                                         attenuation_mode_r[`DMCP_BIT_ATTEN_MODE]);
            o_right_atten_mute    <= atten_is_mute(right_attenuation_r,
                                         attenuation_mode_r[`DMCP_BIT_ATTEN_MODE]);
            o_oversample_boost    <= mute_reset_oversampling_r[`DMCP_BIT_OVERSAMPLE];
            o_left_dac_disable    <= deemphasis_dac_enable_r[`DMCP_BIT_LEFT_DAC];
            o_right_dac_disable   <= deemphasis_dac_enable_r[`DMCP_BIT_RIGHT_DAC];
            o_rolloff_select      <= format_and_filter_r[`DMCP_BIT_ROLLOFF];
            o_atten_mode_select   <= attenuation_mode_r[`DMCP_BIT_ATTEN_MODE];
            o_output_phase_invert <= phase_and_flag_options_r[`DMCP_BIT_PHASE];
            o_soft_reset_active   <= soft_reset_bit_busy_r | soft_reset_bit_req;
            if (PIN_CONTROL != 0) begin
                o_left_soft_mute     <= mute_s;
                o_right_soft_mute    <= mute_s;
                o_deemph_enable      <= dm_hi_s | dm_lo_s;
                o_deemph_rate_select <= pin_rate;
                o_format_field       <= fmt_nxt;
            end else begin
                o_left_soft_mute     <= mute_reset_oversampling_r[`DMCP_BIT_LEFT_MUTE];
                o_right_soft_mute    <= mute_reset_oversampling_r[`DMCP_BIT_RIGHT_MUTE];
                o_deemph_enable      <= deemphasis_dac_enable_r[`DMCP_BIT_DEEMPH_EN];
                o_deemph_rate_select <= deemphasis_dac_enable_r[6:5];
                o_format_field       <= format_and_filter_r[2:0];
            end
        end
    end

endmodule

// ==== sim/dmcp_assertions.sv ====
`timescale 1ns/1ns
module dmcp_assertions (
    // watched top-level ports
    input wire       i_clk,
    input wire       i_rst_n,
    input wire       i_port_select_n,
    input wire [7:0] o_left_atten_level,
    input wire       o_left_atten_mute,
    input wire       o_atten_mode_select,
    input wire [2:0] o_format_field,
    input wire       o_soft_reset_active
);
default clocking @(posedge i_clk);
endclocking
default disable iff (!i_rst_n);
// soft reset runs about 1024 clocks, far beyond any repetition
reg [10:0] soft_reset_bit_cnt_r;
always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
        soft_reset_bit_cnt_r <= 11'h000;
    else
        soft_reset_bit_cnt_r <= o_soft_reset_active ? soft_reset_bit_cnt_r + 11'h001 : 11'h000;
AST_RST_ATTEN: assert property ($rose(i_rst_n) |-> o_left_atten_level == 8'hff)
    else $error("attenuation not 0 dB after reset");
AST_LEFT_MUTE: assert property (($stable(o_left_atten_level)
    && $stable(o_atten_mode_select)) [*2]
    |-> o_left_atten_mute == (o_left_atten_level <= (o_atten_mode_select ? 8'h9a : 8'h80)))
    else $error("mute flag does not match code");
AST_SOFT_RESET_BIT_LEN: assert property ($fell(o_soft_reset_active)
    |-> soft_reset_bit_cnt_r >= 11'h3ff && soft_reset_bit_cnt_r <= 11'h406)
    else $error("soft reset period wrong");
AST_SOFT_RESET_BIT_DEFAULT: assert property ($past(o_soft_reset_active) && o_soft_reset_active
    |-> o_left_atten_level == 8'hff && o_format_field == 3'h0 && !o_atten_mode_select)
    else $error("registers not default in soft reset");
AST_SOFT_RESET_BIT_CAUSE: assert property ($rose(o_soft_reset_active)
    |-> i_port_select_n && $past(i_port_select_n, 3))
    else $error("soft reset without a committed word");
AST_ATTEN_COMMIT: assert property ($changed(o_left_atten_level)
    |-> i_port_select_n && $past(i_port_select_n, 3))
    else $error("attenuation changed outside a commit");
AST_MODE_COMMIT: assert property ($changed(o_atten_mode_select)
    |-> i_port_select_n && $past(i_port_select_n, 3))
    else $error("mode changed outside a commit");
AST_FRAME_HOLD: assert property (!i_port_select_n [*6]
    |-> $stable(o_format_field) && $stable(o_left_atten_level))
    else $error("register changed inside a frame");
endmodule
bind dmcp_top dmcp_assertions dmcp_assertions_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_port_select_n(i_port_select_n), .o_left_atten_level(o_left_atten_level),
    .o_left_atten_mute(o_left_atten_mute), .o_atten_mode_select(o_atten_mode_select),
    .o_format_field(o_format_field), .o_soft_reset_active(o_soft_reset_active));

// ==== sim/dmcp_host_model.sv ====
`timescale 1ns/1ns
module dmcp_host_model (
    // serial port pins
    output logic o_port_select_n    = 1'b1,
    output logic o_port_shift_clock = 1'b0,
    output logic o_port_serial_in   = 1'b0
);
// clock stands still between frames; data flips once released
// h sets half a shift-clock period
task automatic send(input logic [15:0] w, input int n, input int h);
    o_port_select_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
        o_port_serial_in = (i == 15) ? 1'b0 : w[i];
        #(h) o_port_shift_clock = 1'b1;
        #(h) o_port_shift_clock = 1'b0;
    end
    #(h) o_port_select_n = 1'b1;
    o_port_serial_in = ~o_port_serial_in;
endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
logic        i_clk = 1'b0;
logic        i_rst_n = 1'b0;
logic [23:0] left_s = 24'h1;
logic [23:0] right_s = 24'h1;
logic [2:0]  wc_cnt = 3'h0;
wire         sel_n, sck, sdi, lam, ram, pzf;
wire  [2:0]  flg;
wire  [7:0]  pv;
logic [3:0]  pins = 4'h0;
wire  [55:0] regv;
int          n_errors = 0;
int          n_checks = 0;
logic [15:0] wtab [7] = '{16'h10a5, 16'h115a, 16'h127f, 16'h13ff, 16'h14ff, 16'h15ff, 16'h1601};
logic [7:0]  etab [7] = '{8'ha5, 8'h5a, 8'h43, 8'h73, 8'h27, 8'h01, 8'h01};
logic [8:0]  mtab [4] = '{9'h19a, 9'h19b, 9'h080, 9'h081};
// {format, rate hi, rate lo, mute straps} then the mode byte they select
logic [11:0] ptab [4] = '{12'h004, 12'hbe8, 12'h424, 12'he30};
// reserved places read as zero so each byte of regv mirrors one register
assign {regv[37:34], regv[31], regv[27:26], regv[23:22], regv[20:19], regv[15:9],
        regv[7:1]} = 25'h0;
always #4 i_clk = ~i_clk;
// eight-clock word period keeps the zero tests short
always @(posedge i_clk) wc_cnt <= #1 wc_cnt + 3'h1;
initial begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    give_verdict();
end
dmcp_host_model dmcp_host_model_i (.o_port_select_n(sel_n), .o_port_shift_clock(sck),
    .o_port_serial_in(sdi));
dmcp_top dmcp_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_port_select_n(sel_n),
    .i_port_shift_clock(sck), .i_port_serial_in(sdi), .i_format_pin(1'b0), .i_mute_pin(1'b0),
    .i_deemph_sel_hi_pin(1'b0), .i_deemph_sel_lo_pin(1'b0), .i_word_clock(wc_cnt[2]),
    .i_left_sample(left_s), .i_right_sample(right_s), .o_left_zero_flag(flg[2]),
    .o_right_zero_flag(flg[1]), .o_common_zero_flag(flg[0]), .o_left_atten_level(regv[55:48]),
    .o_right_atten_level(regv[47:40]), .o_left_atten_mute(lam), .o_right_atten_mute(ram),
    .o_soft_reset_active(regv[39]), .o_oversample_boost(regv[38]), .o_right_soft_mute(regv[33]),
    .o_left_soft_mute(regv[32]), .o_deemph_rate_select(regv[30:29]), .o_deemph_enable(regv[28]),
    .o_right_dac_disable(regv[25]), .o_left_dac_disable(regv[24]), .o_rolloff_select(regv[21]),
    .o_format_field(regv[18:16]), .o_atten_mode_select(regv[8]), .o_output_phase_invert(regv[0]));
// pin-strapped variant shares the sample stream; its serial port stays idle
dmcp_top #(.PIN_CONTROL(1)) dmcp_top_pin_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_port_select_n(1'b1), .i_port_shift_clock(1'b0), .i_port_serial_in(1'b0),
    .i_format_pin(pins[3]), .i_deemph_sel_hi_pin(pins[2]), .i_deemph_sel_lo_pin(pins[1]),
    .i_mute_pin(pins[0]), .i_word_clock(wc_cnt[2]), .i_left_sample(left_s),
    .i_right_sample(right_s), .o_left_zero_flag(), .o_right_zero_flag(),
    .o_common_zero_flag(pzf), .o_left_atten_level(), .o_right_atten_level(),
    .o_left_atten_mute(), .o_right_atten_mute(), .o_left_soft_mute(pv[7]),
    .o_right_soft_mute(pv[6]), .o_oversample_boost(), .o_left_dac_disable(),
    .o_right_dac_disable(), .o_deemph_enable(pv[5]), .o_deemph_rate_select(pv[4:3]),
    .o_rolloff_select(), .o_format_field(pv[2:0]), .o_atten_mode_select(),
    .o_output_phase_invert(), .o_soft_reset_active());
task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
endtask
task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
endtask
// a write is committed about four clocks after select rises
task automatic wr(input logic [15:0] w, input int n, input int h);
    step(1);
    dmcp_host_model_i.send(w, n, h);
    step(12);
endtask
task automatic t_regs();
    for (int i = 0; i < 7; i++)
        chk(regv[55-8*i -: 8], (i < 2) ? 8'hff : 8'h00);
    chk({5'h0, flg}, 8'h00);
    for (int i = 0; i < 7; i++) begin
        wr(wtab[i], 16, 80);
        chk(regv[55-8*i -: 8], etab[i]);
    end
    wr(16'h17ff, 16, 80);
    wr(16'h0f00, 16, 80);
    wr(16'h1000, 15, 80);
    for (int i = 0; i < 7; i++)
        chk(regv[55-8*i -: 8], etab[i]);
    for (int i = 0; i < 4; i++) begin
        wr({8'h15, 7'h0, mtab[i][8]}, 16, 80);
        wr({8'h10, mtab[i][7:0]}, 16, 80);
        chk({7'h0, lam}, {7'h0, ~mtab[i][0]});
    end
    chk({7'h0, ram}, 8'h01);
    $display("register test done");
endtask
task automatic t_zero();
    wr(16'h1600, 16, 80);
    left_s = 24'h0;
    step(8160);
    chk({5'h0, flg}, 8'h00);
    step(100);
    chk({5'h0, flg}, 8'h04);
    chk({7'h0, pzf}, 8'h00);
    wr(16'h1604, 16, 80);
    chk({5'h0, flg}, 8'h00);
    wr(16'h1602, 16, 80);
    chk({5'h0, flg}, 8'h02);
    right_s = 24'h0;
    step(8300);
    chk({5'h0, flg}, 8'h01);
    chk({7'h0, pzf}, 8'h01);
    $display("zero flag test done");
endtask
task automatic t_soft_reset_bit();
    int k;
    wr(16'h1280, 16, 80);
    chk({7'h0, regv[39]}, 8'h01);
    wr(16'h1044, 16, 80);
    for (k = 0; k < 1200 && regv[39] === 1'b1; k++)
        step(1);
    chk({7'h0, regv[39]}, 8'h00);
    chk(regv[55:48], 8'hff);
    chk({5'h0, flg}, 8'h00);
    $display("soft reset test done");
endtask
task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
        pins = ptab[i][11:8];
        step(5);
        chk(pv, ptab[i][7:0]);
    end
    $display("pin control test done");
endtask
initial begin
    step(10);
    i_rst_n = 1'b1;
    step(4);
    t_regs();
    t_zero();
    t_soft_reset_bit();
    t_pins();
    give_verdict();
end
endmodule
